/* bench/drb_checker_assertions.sv */
// Purpose: port checks for drb_diag_record_builder
// Assumes: one clock, nrst active low
// Notes: bind at file foot
`timescale 1ns/1ps
`default_nettype none
module drb_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire drb_pkg::drb_mode_e op_mode,
  input wire logic diag_handler_call,
  input wire logic diag_outgoing,
  input wire logic [31:0] local_dword8,
  input wire logic buf_entry_valid,
  input wire logic [7:0] buf_entry_cause
);
  import drb_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_b0_zero: assert property (local_dword8[7:5] == 3'h0) else $error("b0 top");
  a_b2_zero: assert property ({local_dword8[23:21], local_dword8[19:16]} == 7'h00) else $error("b2");
  a_b3_zero: assert property ({local_dword8[31], local_dword8[29:24]} == 7'h00) else $error("b3");
  a_int_fail: assert property (local_dword8[1] |-> local_dword8[0]) else $error("b0 int");
  a_chan_info: assert property (local_dword8[12] == local_dword8[0]) else $error("b1 info");
  a_out_clear: assert property (diag_outgoing |-> local_dword8[31:24] == 8'h00) else $error("out b3");
  a_buf_cause: assert property (diag_handler_call |->
    buf_entry_valid && buf_entry_cause == local_dword8[7:0]) else $error("buf");
  a_class_code: assert property (diag_handler_call |->
    local_dword8[11:8] == ($past(op_mode) == DRB_MODE_ALARM ? 4'hF : 4'h8)) else $error("class");
  c_call: cover property (diag_handler_call);
  c_out: cover property (diag_outgoing);
  c_lost: cover property (local_dword8[30]);
endmodule // drb_checker
bind drb_diag_record_builder drb_checker u_chk (.core_clk, .nrst, .op_mode, .diag_handler_call,
  .diag_outgoing, .local_dword8, .buf_entry_valid, .buf_entry_cause);
`default_nettype wire

/* bench/drb_cpu_model.sv */
// Purpose: cpu side model ending process irq handling
// Assumes: done two cycles after irq unless stalled
// Notes: stall keeps channels busy
`timescale 1ns/1ps
`default_nettype none
module drb_cpu_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic [15:0] process_irq,
  output logic [15:0] process_irq_done
);
  logic [15:0] busy_reg;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) busy_reg <= 16'h0000;
    else busy_reg <= stall ? busy_reg | process_irq : process_irq;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) process_irq_done <= 16'h0000;
    else process_irq_done <= stall ? 16'h0000 : busy_reg;
endmodule // drb_cpu_model
`default_nettype wire

/* bench/test_diag_record_builder.sv */
// Purpose: bench for drb_diag_record_builder
// Assumes: drive on falling edge
// Notes: reset, table rows, then disable, read, lost, reset again cases
`timescale 1ns/1ps
`default_nettype none
module test_diag_record_builder;
  import drb_pkg::*;
  logic core_clk = 1'h0, nrst = 1'h0, diag_enable = 1'h1, rd_req = 1'h0, st = 1'h0;
  drb_mode_e op_mode = DRB_MODE_ALARM;
  logic [4:0] f = 5'h00;
  logic [3:0] rd_index = 4'h0;
  logic [15:0] pirq = 16'h0000, pdone, buf_entry_addr;
  logic [95:0] ext = 96'hF1E2D3C4B5A6978879605142;
  logic [7:0] rd_data, buf_entry_cause;
  logic [31:0] local_dword8;
  logic rd_valid, diag_handler_call, diag_outgoing, buf_entry_valid;
  int err_total = 0, n_compared = 0;
  logic [30:0] rows [4] = '{{2'h0, 5'h10, 24'h101F03}, {2'h1, 5'h04, 24'h00180B},
    {2'h3, 5'h0B, 24'h101817}, {2'h2, 5'h12, 24'h101807}};
  logic [3:0] ri [3] = '{4'h0, 4'h4, 4'hF};
  logic [7:0] re [3] = '{8'h0B, 8'h42, 8'hF1};
  always #5 core_clk = ~core_clk;
  drb_diag_record_builder #(.MODULE_ADDR(16'h00A5)) dut (.core_clk, .nrst, .op_mode, .diag_enable,
    .process_irq(pirq), .process_irq_done(pdone), .input_power_section_missing(f[4]),
    .output_supply_missing(f[3]), .output_short(f[2]), .external_error(f[1]), .external_supply_missing(f[0]),
    .ext_module_data(ext), .rd_index, .rd_req, .rd_data, .rd_valid, .diag_handler_call, .diag_outgoing,
    .local_dword8, .buf_entry_valid, .buf_entry_cause, .buf_entry_addr);
  drb_cpu_model cpu (.core_clk, .nrst, .stall(st), .process_irq(pirq), .process_irq_done(pdone));
  task automatic chk(input string nm, input logic [39:0] e, g);
    n_compared++;
    if (g !== e) err_total++;
    if (g !== e) $display("[ERR] %s exp %h got %h", nm, e, g);
  endtask
  task nf(input logic [6:0] v);
    @(negedge core_clk);
    op_mode = drb_mode_e'(v[6:5]);
    f = v[4:0];
    @(posedge core_clk);
    #1;
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'h1;
    #1;
    chk("rst", 40'h0, {local_dword8, diag_handler_call, rd_valid});
    $display("reset done");
    for (int i = 0; i < 4; i++)
    begin
      nf(rows[i][30:24]);
      chk("rec", rows[i][23:0], local_dword8);
      chk("buf", {2'h3, rows[i][7:0], 16'h00A5}, {diag_handler_call, buf_entry_valid, buf_entry_cause, buf_entry_addr});
      nf({rows[i][30:29], 5'h00});
      chk("out", {2'h3, 20'h00000, rows[i][11:8], 8'h00}, {diag_handler_call, diag_outgoing, local_dword8});
      $display("row %0d done", i);
    end
    @(negedge core_clk) diag_enable = 1'h0;
    nf({2'h2, 5'h04});
    chk("off", {1'h0, 32'h0000180B}, {diag_handler_call, local_dword8});
    for (int j = 0; j < 3; j++)
    begin
      @(negedge core_clk) {rd_req, rd_index} = {1'h1, ri[j]};
      @(posedge core_clk) #1;
      chk("rd", {1'h1, re[j]}, {rd_valid, rd_data});
      @(negedge core_clk) rd_req = 1'h0;
    end
    nf({2'h2, 5'h00});
    @(negedge core_clk) diag_enable = 1'h1;
    $display("disable done");
    @(negedge core_clk) st = 1'h1;
    repeat (2)
    begin
      @(negedge core_clk) pirq = 16'h0004;
      @(negedge core_clk) pirq = 16'h0000;
    end
    for (int k = 0; k < 8 && diag_handler_call !== 1'h1; k++)
      @(posedge core_clk) #1;
    chk("lost", {1'h1, 32'h40001809}, {diag_handler_call, local_dword8});
    $display("lost done");
    @(negedge core_clk) st = 1'h0;
    for (int k = 0; k < 8 && diag_outgoing !== 1'h1; k++)
      @(posedge core_clk) #1;
    chk("lost out", {1'h1, 32'h00000800}, {diag_outgoing, local_dword8});
    $display("lost out done");
    nf({2'h0, 5'h04});
    @(negedge core_clk) {nrst, f} = 6'h00;
    #1;
    chk("rst2", 40'h0, {local_dword8, diag_handler_call, buf_entry_valid, rd_valid});
    @(negedge core_clk) nrst = 1'h1;
    @(posedge core_clk) #1;
    chk("rst3", 40'h0, {local_dword8, diag_handler_call, diag_outgoing, rd_valid});
    $display("reset again done");
    give_verdict;
  end
  initial
  begin
    #20000 err_total++;
    give_verdict;
  end
endmodule // test_diag_record_builder
`default_nettype wire

/* core/drb_diag_record_builder.sv */
// Purpose: builds the basic and extended diagnostic records
// Assumes: fault inputs come from logic on core_clk
// Notes: record frozen between diagnostic events
//
// Functional notes
// - byte 0 bit 0 flags module failure: lost irq, missing supply, short/overload.
// - byte 0 bit 1 flags internal error: missing supply or output short/overload.
// - byte 0 bits 2,3,4 external, channel, external supply; bits 7-5 zero.
// - byte 1 bits 3-0 module class 1111b digital, 1000b function; 7-5 zero.
// - byte 1 bit 4 channel info present for lost irq, supply, short.
// - byte 2 bit 4 missing internal supply; other bits zero.
// - incoming record byte 3 bit 6 flags lost process interrupt, rest zero.
// - outgoing record after error clears all but module class; byte 3 zero.
// - each handler call yields one buffer entry with cause and address.
// - basic record ready in record output before the handler starts.
// - with diagnostic interrupt disabled, reads give the latest event.
// - extended record set readable on request via record read service.
// - basic record layout same for all operating modes.
// - extended record is basic four bytes plus twelve module bytes.
// - repeat process irq for same event while handled raises diagnostic.
`timescale 1ns/1ps
`default_nettype none
`include "drb_params.svh"
module drb_diag_record_builder
  import drb_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter logic [15:0] MODULE_ADDR = 16'h0000
)(
  input wire logic core_clk,
  input wire logic nrst,
  input wire drb_pkg::drb_mode_e op_mode,
  input wire logic diag_enable,
  input wire logic [CHANNELS-1:0] process_irq,
  input wire logic [CHANNELS-1:0] process_irq_done,
  input wire logic input_power_section_missing,
  input wire logic output_supply_missing,
  input wire logic output_short,
  input wire logic external_error,
  input wire logic external_supply_missing,
  input wire logic [95:0] ext_module_data,
  input wire logic [3:0] rd_index,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic diag_handler_call,
  output logic diag_outgoing,
  output logic [31:0] local_dword8,
  output logic buf_entry_valid,
  output logic [7:0] buf_entry_cause,
  output logic [15:0] buf_entry_addr
);
  import drb_pkg::*;

  // ----------------------------------------
  // lost process interrupt detection
  // ----------------------------------------
  logic [CHANNELS-1:0] busy_reg;
  logic [CHANNELS-1:0] lost_reg;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_ch
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          busy_reg[g] <= 1'b0;
        else if (process_irq[g])
          busy_reg[g] <= 1'b1;
        else if (process_irq_done[g])
          busy_reg[g] <= 1'b0;
      end
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          lost_reg[g] <= 1'b0;
        else if (process_irq[g] && busy_reg[g])
          lost_reg[g] <= 1'b1;
        else if (process_irq_done[g])
          lost_reg[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // live fault image, only module class depends on mode
  // ----------------------------------------
  logic supply_missing;
  logic any_lost;
  logic fault_now;
  logic [31:0] live_rec;
  logic [3:0] mod_class;
  assign supply_missing = input_power_section_missing | output_supply_missing;
  assign any_lost = |lost_reg;
  assign fault_now = any_lost | supply_missing | output_short | external_error | external_supply_missing;
  assign mod_class = (op_mode == DRB_MODE_ALARM) ? `DRB_CLASS_DIGITAL : `DRB_CLASS_FUNCTION;
  always_comb
  begin
    live_rec = 32'h0000_0000;
    live_rec[`DRB_B0_FAIL] = any_lost | supply_missing | output_short;
    live_rec[`DRB_B0_INT] = supply_missing | output_short;
    live_rec[`DRB_B0_EXT] = external_error;
    live_rec[`DRB_B0_CHAN] = any_lost | output_short;
    live_rec[`DRB_B0_EXTSUP] = external_supply_missing;
    live_rec[8 +: 4] = mod_class;
    live_rec[8 + `DRB_B1_CHINFO] = any_lost | supply_missing | output_short;
    live_rec[16 + `DRB_B2_INTSUP] = supply_missing;
    live_rec[24 + `DRB_B3_LOST] = any_lost;
  end

  // ----------------------------------------
  // incoming / outgoing event sequencing
  // ----------------------------------------
  drb_state_e state_reg;
  logic ev_in;
  logic ev_out;
  assign ev_in = (state_reg == DRB_ST_IDLE) && fault_now;
  assign ev_out = (state_reg == DRB_ST_ACTIVE) && !fault_now;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= DRB_ST_IDLE;
    else
    begin
      case (state_reg)
        DRB_ST_IDLE:
          if (fault_now)
            state_reg <= DRB_ST_ACTIVE;
        DRB_ST_ACTIVE:
          if (!fault_now)
            state_reg <= DRB_ST_IDLE;
        default:
          state_reg <= DRB_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // frozen record and extended data
  // ----------------------------------------
  logic [31:0] rec_reg;
  logic [95:0] ext_reg;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rec_reg <= 32'h0000_0000;
    else if (ev_in)
      rec_reg <= live_rec;
    else if (ev_out)
      rec_reg <= {8'h00, live_rec[23:0]};
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ext_reg <= 96'h0;
    else if (ev_in || ev_out)
      ext_reg <= ext_module_data;
  end
  assign local_dword8 = rec_reg;

  // ----------------------------------------
  // handler call and diagnostic buffer entry
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      diag_handler_call <= 1'b0;
      diag_outgoing <= 1'b0;
    end
    else
    begin
      diag_handler_call <= diag_enable && (ev_in || ev_out);
      diag_outgoing <= diag_enable && ev_out;
    end
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_entry_valid <= 1'b0;
      buf_entry_cause <= `DRB_REC_RESET;
      buf_entry_addr <= 16'h0000;
    end
    else
    begin
      buf_entry_valid <= diag_enable && (ev_in || ev_out);
      if (ev_in || ev_out)
      begin
        buf_entry_cause <= live_rec[7:0];
        buf_entry_addr <= MODULE_ADDR;
      end
    end
  end

  // ----------------------------------------
  // record read service
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (rd_index < 4'(`DRB_BASIC_BYTES))
      rd_byte = rec_reg[rd_index[1:0]*8 +: 8];
    else
      rd_byte = ext_reg[(rd_index - 4'(`DRB_BASIC_BYTES))*8 +: 8];
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data <= `DRB_REC_RESET;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_req;
      if (rd_req)
        rd_data <= rd_byte;
    end
  end
endmodule // drb_diag_record_builder
`default_nettype wire

/* core/drb_params.svh */
// Purpose: constants for the diagnostic record builder
// Assumes: byte-wide record reads, indices 0 to 15
// Notes: definitions only
`ifndef DRB_PARAMS_SVH
`define DRB_PARAMS_SVH
// ----------------------------------------
// basic record byte offsets
// ----------------------------------------
`define DRB_OFS_ERROR_SUMMARY 4'h0
`define DRB_OFS_MODULE_CLASS 4'h1
`define DRB_OFS_INTERNAL_SUPPLY 4'h2
`define DRB_OFS_IRQ_LOST 4'h3
`define DRB_BASIC_BYTES 4
`define DRB_EXT_BYTES 16
// ----------------------------------------
// field positions
// ----------------------------------------
`define DRB_B0_FAIL 0
`define DRB_B0_INT 1
`define DRB_B0_EXT 2
`define DRB_B0_CHAN 3
`define DRB_B0_EXTSUP 4
`define DRB_B1_CHINFO 4
`define DRB_B2_INTSUP 4
`define DRB_B3_LOST 6
// ----------------------------------------
// module class codes and reset byte
// ----------------------------------------
`define DRB_CLASS_DIGITAL 4'hF
`define DRB_CLASS_FUNCTION 4'h8
`define DRB_REC_RESET 8'h00
`endif

/* core/drb_pkg.sv */
// Purpose: types for the diagnostic record builder
// Assumes: nothing
// Notes: operating modes of the channels
package drb_pkg;
  typedef enum logic [1:0] {DRB_MODE_ALARM, DRB_MODE_COUNTER, DRB_MODE_FREQ, DRB_MODE_PWM} drb_mode_e;
  typedef enum logic [1:0] {DRB_ST_IDLE, DRB_ST_ACTIVE} drb_state_e;
endpackage
